// ---- btsd_regs.svh ----
// constants for the bit test and skip decoder
// assumes inclusion by the decoder only
`ifndef BTSD_REGS_SVH
`define BTSD_REGS_SVH
`define BTSD_OP_CLEAR 4'hB
`define BTSD_OP_SET 4'hA
`define BTSD_OP_POS 12
`define BTSD_BIT_POS 9
`define BTSD_FLAG_POS 8
`define BTSD_ILO_MAX 8'h5F
`define BTSD_ACCESS_SPLIT 8'h60
`define BTSD_ACCESS_HIGH_BANK 4'hF
`define BTSD_SKIP_ONE 2'h1
`define BTSD_SKIP_TWO 2'h2
`endif

// ---- btsd_pkg.sv ----
// types for the bit test and skip decoder
// assumes btsd_regs.svh sits in the include path
package btsd_pkg;
    typedef enum logic [1:0] {
        BTSD_Q1,
        BTSD_Q2,
        BTSD_Q3,
        BTSD_Q4
    } btsd_phase_e;
    typedef enum logic [1:0] {
        BTSD_MODE_ACCESS,
        BTSD_MODE_BANKED,
        BTSD_MODE_INDEXED
    } btsd_mode_e;
    typedef struct packed {
        logic [3:0] bank;
        logic [7:0] offset;
    } btsd_addr_s;
endpackage

// ---- btsd_decoder.sv ----
// bit test and skip decode and execute for an 8-bit core
// assumes fetch unit supplies instruction word at q1 and register data by q3
//
// Function
// - top nibble 1011 is skip_if_bit_clear, 1010 is skip_if_bit_set.
// - skip_if_bit_clear skips next instruction when selected bit reads zero.
// - skip_if_bit_set skips next instruction when selected bit reads one.
// - taken skip discards prefetched instruction and executes a no-operation instead.
// - flag 0 selects access bank, flag 1 uses bank_select_reg bank.
// - extended set, flag 0, address up to 5Fh uses indexed literal offset.
`include "btsd_regs.svh"
module btsd_decoder (
    input wire logic mclk_in,
    input wire logic rst_in,
    input wire logic [15:0] instr_in,
    input wire logic instr_valid_in,
    input wire logic next_two_word_in,
    input wire logic ext_set_en_in,
    input wire logic [3:0] bank_select_reg_in,
    input wire logic [7:0] file_data_in,
    output logic [1:0] phase_out,
    output logic is_bit_test_out,
    output logic [11:0] read_addr_out,
    output logic read_indexed_out,
    output logic read_en_out,
    output logic skip_out,
    output logic squash_out,
    output logic [1:0] nop_cycles_out
);
    btsd_pkg::btsd_phase_e phase_reg;
    logic [15:0] instr_reg;
    logic active_reg;
    logic skip_reg;
    logic [1:0] nop_cycles_reg;
    btsd_pkg::btsd_mode_e mode_next;
    btsd_pkg::btsd_addr_s addr_next;
    logic is_clear;
    logic is_set;
    logic [2:0] bit_idx;
    logic flag;
    logic [7:0] faddr;
    logic test_bit;

    // quarter cycle sequencer runs free; one instruction cycle is four clocks
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            phase_reg <= btsd_pkg::BTSD_Q1;
        end else begin
            case (phase_reg)
                btsd_pkg::BTSD_Q1: phase_reg <= btsd_pkg::BTSD_Q2;
                btsd_pkg::BTSD_Q2: phase_reg <= btsd_pkg::BTSD_Q3;
                btsd_pkg::BTSD_Q3: phase_reg <= btsd_pkg::BTSD_Q4;
                btsd_pkg::BTSD_Q4: phase_reg <= btsd_pkg::BTSD_Q1;
                default: phase_reg <= btsd_pkg::BTSD_Q1;
            endcase
        end
    end

    // fields come from the latched copy, so fetch bus changes cannot disturb q2 to q4
    assign is_clear = instr_reg[15:`BTSD_OP_POS] == `BTSD_OP_CLEAR;
    assign is_set = instr_reg[15:`BTSD_OP_POS] == `BTSD_OP_SET;
    assign bit_idx = instr_reg[`BTSD_BIT_POS+2:`BTSD_BIT_POS];
    assign flag = instr_reg[`BTSD_FLAG_POS];
    assign faddr = instr_reg[7:0];
    assign test_bit = file_data_in[bit_idx];

    // latch the word at q1; a squashed slot is never latched as live
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            instr_reg <= 16'h0000;
            active_reg <= 1'b0;
        end else if (phase_reg == btsd_pkg::BTSD_Q1) begin
            instr_reg <= instr_in;
            active_reg <= instr_valid_in && nop_cycles_reg == 2'h0 && !skip_reg;
        end
    end

    always_comb begin
        mode_next = btsd_pkg::BTSD_MODE_BANKED;
        addr_next.bank = bank_select_reg_in;
        addr_next.offset = faddr;
        if (!flag) begin
            if (ext_set_en_in && faddr <= `BTSD_ILO_MAX) begin
                mode_next = btsd_pkg::BTSD_MODE_INDEXED;
                addr_next.bank = 4'h0;
            end else begin
                // upper part of the access bank reaches the special function registers
                mode_next = btsd_pkg::BTSD_MODE_ACCESS;
                addr_next.bank = (faddr < `BTSD_ACCESS_SPLIT) ? 4'h0 : `BTSD_ACCESS_HIGH_BANK;
            end
        end
    end

    // q2 reads register; q3 decides; q4 idles
    // cleared again at q1, so skip_out stands exactly two clocks
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            skip_reg <= 1'b0;
        end else if (phase_reg == btsd_pkg::BTSD_Q3) begin
            skip_reg <= active_reg && ((is_clear && !test_bit) || (is_set && test_bit));
        end else if (phase_reg == btsd_pkg::BTSD_Q1) begin
            skip_reg <= 1'b0;
        end
    end

    // count pending extra no-operation slots: none, or one when the skipped word is double
    always_ff @(posedge mclk_in) begin
        if (rst_in) begin
            nop_cycles_reg <= 2'h0;
        end else if (phase_reg == btsd_pkg::BTSD_Q1) begin
            if (skip_reg) begin
                nop_cycles_reg <= next_two_word_in ? `BTSD_SKIP_ONE : 2'h0;
            end else if (nop_cycles_reg != 2'h0) begin
                nop_cycles_reg <= nop_cycles_reg - 2'h1;
            end
        end
    end

    assign phase_out = phase_reg;
    assign is_bit_test_out = active_reg && (is_clear || is_set);
    assign read_addr_out = addr_next;
    assign read_indexed_out = mode_next == btsd_pkg::BTSD_MODE_INDEXED;
    assign read_en_out = is_bit_test_out && phase_reg == btsd_pkg::BTSD_Q2;
    assign skip_out = skip_reg;
    assign squash_out = phase_reg == btsd_pkg::BTSD_Q1 && (skip_reg || nop_cycles_reg != 2'h0);
    assign nop_cycles_out = nop_cycles_reg;

    // decision: both outcomes of each opcode
    skip_clear_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        phase_reg == btsd_pkg::BTSD_Q3 && active_reg && is_clear && !test_bit |=> skip_reg)
        else $error("clear bit did not skip");
    skip_set_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        phase_reg == btsd_pkg::BTSD_Q3 && active_reg && is_set && test_bit |=> skip_reg)
        else $error("set bit did not skip");
    clear_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        phase_reg == btsd_pkg::BTSD_Q3 && active_reg && is_clear && test_bit |=> !skip_reg)
        else $error("clear test skipped on set bit");
    set_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        phase_reg == btsd_pkg::BTSD_Q3 && active_reg && is_set && !test_bit |=> !skip_reg)
        else $error("set test skipped on clear bit");
    no_skip_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        phase_reg == btsd_pkg::BTSD_Q3 && !(is_clear || is_set) |=> !skip_reg)
        else $error("skip from other opcode");
    skip_opcode_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        skip_reg |-> is_clear || is_set)
        else $error("skip without bit test word");

    // squash and slot accounting
    squash_slot_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        skip_reg && phase_reg == btsd_pkg::BTSD_Q4 |=> squash_out ##1 !active_reg)
        else $error("prefetch not squashed");
    skip_hold_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        $rose(skip_reg) |-> phase_reg == btsd_pkg::BTSD_Q4 ##1 skip_reg ##1 !skip_reg)
        else $error("skip not held for two clocks");
    squash_q1_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        squash_out |-> phase_reg == btsd_pkg::BTSD_Q1)
        else $error("squash outside q1");
    refuse_word_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        squash_out |=> !active_reg)
        else $error("squashed word went live");
    no_read_squash_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        !active_reg |-> !read_en_out)
        else $error("read for a dead slot");
    two_word_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        skip_reg && phase_reg == btsd_pkg::BTSD_Q1 && next_two_word_in |=> ##3 squash_out)
        else $error("second word not squashed");
    one_cycle_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        phase_reg == btsd_pkg::BTSD_Q4 && !skip_reg && nop_cycles_reg == 2'h0 |=> !squash_out)
        else $error("squash without skip");
    nop_no_skip_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        nop_cycles_reg != 2'h0 |-> !skip_reg)
        else $error("skip inside a no-operation slot");
    nop_bound_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        nop_cycles_reg <= `BTSD_SKIP_ONE)
        else $error("too many pending no-operation slots");
    refused_nop_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        phase_reg == btsd_pkg::BTSD_Q1 && nop_cycles_reg != 2'h0 |=> !active_reg)
        else $error("second word went live");

    // operand addressing; the indexed offset add is left to the register file
    access_bank_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        !flag && !ext_set_en_in |-> mode_next == btsd_pkg::BTSD_MODE_ACCESS)
        else $error("access bank not chosen");
    banked_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        flag |-> addr_next.bank == bank_select_reg_in)
        else $error("bank select not used");
    banked_offset_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        flag |-> addr_next.offset == faddr && !read_indexed_out)
        else $error("banked offset wrong");
    high_bank_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        !flag && !read_indexed_out && faddr >= `BTSD_ACCESS_SPLIT |-> addr_next.bank == `BTSD_ACCESS_HIGH_BANK)
        else $error("upper access half misrouted");
    low_access_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        !flag && !read_indexed_out && faddr < `BTSD_ACCESS_SPLIT |-> addr_next.bank == 4'h0)
        else $error("lower access half misrouted");
    indexed_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        !flag && ext_set_en_in && faddr <= `BTSD_ILO_MAX |-> read_indexed_out)
        else $error("indexed mode missed");
    indexed_bank_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        read_indexed_out |-> addr_next.bank == 4'h0 && !flag && ext_set_en_in)
        else $error("indexed mode out of place");
    no_index_high_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        faddr > `BTSD_ILO_MAX |-> !read_indexed_out)
        else $error("indexed mode above limit");

    // quarter cycle and read timing
    read_q2_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        read_en_out |-> phase_reg == btsd_pkg::BTSD_Q2 ##1 phase_reg == btsd_pkg::BTSD_Q3)
        else $error("read outside q2");
    q1_step_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        phase_reg == btsd_pkg::BTSD_Q1 |=> phase_reg == btsd_pkg::BTSD_Q2)
        else $error("q1 not followed by q2");
    q4_wrap_a: assert property (@(posedge mclk_in) disable iff (rst_in)
        phase_reg == btsd_pkg::BTSD_Q4 |=> phase_reg == btsd_pkg::BTSD_Q1)
        else $error("q4 not followed by q1");
    skip_taken_c: cover property (@(posedge mclk_in) disable iff (rst_in) skip_reg ##1 squash_out);
    two_word_c: cover property (@(posedge mclk_in) disable iff (rst_in) nop_cycles_reg == `BTSD_SKIP_ONE);
    indexed_c: cover property (@(posedge mclk_in) disable iff (rst_in) read_en_out && read_indexed_out);
    access_c: cover property (@(posedge mclk_in) disable iff (rst_in) read_en_out && !flag && !ext_set_en_in);
    no_skip_c: cover property (@(posedge mclk_in) disable iff (rst_in)
        phase_reg == btsd_pkg::BTSD_Q4 && is_bit_test_out && !skip_reg);
endmodule

// ---- tb.sv ----
// self-checking bench for the bit test and skip decoder
// assumes btsd_pkg and btsd_decoder are compiled first
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk_in = 0, rst_in = 1, instr_valid_in = 0, next_two_word_in = 0, ext_set_en_in = 0;
    logic [15:0] instr_in = '0;
    logic [3:0] bank_select_reg_in = '0;
    logic [7:0] file_data_in = '0;
    logic [1:0] phase_out, nop_cycles_out;
    logic is_bit_test_out, read_indexed_out, read_en_out, skip_out, squash_out;
    logic [11:0] read_addr_out;
    int n_mismatch = 0, cmp_count = 0;
    logic [15:0] cw [6] = '{16'hB05F, 16'hB060, 16'hA1FF, 16'hAF00, 16'hB7A5, 16'h9123};
    always #20 mclk_in = ~mclk_in;
    btsd_decoder u_btsd_decoder (.mclk_in(mclk_in), .rst_in(rst_in), .instr_in(instr_in),
        .instr_valid_in(instr_valid_in), .next_two_word_in(next_two_word_in), .ext_set_en_in(ext_set_en_in),
        .bank_select_reg_in(bank_select_reg_in), .file_data_in(file_data_in), .phase_out(phase_out),
        .is_bit_test_out(is_bit_test_out), .read_addr_out(read_addr_out), .read_indexed_out(read_indexed_out),
        .read_en_out(read_en_out), .skip_out(skip_out), .squash_out(squash_out), .nop_cycles_out(nop_cycles_out));
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(input logic [11:0] seen, input logic [11:0] exp, input string m);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("ERROR %0t %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask
    function automatic btsd_pkg::btsd_addr_s exp_addr(logic [15:0] w, logic ext, logic [3:0] b);
        if (w[8])
            return {b, w[7:0]};
        if (ext && w[7:0] <= 8'h5F)
            return {4'h0, w[7:0]};
        return {(w[7:0] < 8'h60) ? 4'h0 : 4'hF, w[7:0]};
    endfunction
    function automatic logic exp_skip(logic [15:0] w, logic [7:0] d);
        return (w[15:12] == 4'hB) ? !d[w[11:9]] : (w[15:12] == 4'hA) && d[w[11:9]];
    endfunction
    // bounded wait for q4, so a stuck phase counter cannot hang the run
    task automatic wait_q4;
        int i;
        for (i = 0; i < 9; i++) begin
            @(negedge mclk_in);
            if (phase_out === 2'h3)
                break;
        end
        if (i == 9) begin
            n_mismatch++;
            $display("ERROR %0t phase counter stuck", $time);
            end_of_test;
        end
    endtask
    task automatic run_one(input logic [15:0] w, input logic [7:0] d, input logic v, two, ext);
        logic s, bt;
        logic [3:0] b;
        s = v && exp_skip(w, d);
        bt = v && (w[15:13] == 3'h5);
        b = 4'($urandom);
        wait_q4;
        @(posedge mclk_in);
        instr_in <= w;
        file_data_in <= d;
        instr_valid_in <= v;
        next_two_word_in <= two;
        ext_set_en_in <= ext;
        bank_select_reg_in <= b;
        repeat (2) @(negedge mclk_in);
        chk(is_bit_test_out, bt, "decode");
        chk(phase_out, 2'h1, "quarter cycle");
        chk(read_en_out, bt, "read strobe");
        if (bt) begin
            chk(read_addr_out, exp_addr(w, ext, b), "operand address");
            chk(read_indexed_out, ext && !w[8] && w[7:0] <= 8'h5F, "indexed");
        end
        repeat (2) @(negedge mclk_in);
        chk(skip_out, s, "skip decision");
        // word stays live in the squashed slot so refusal is seen
        @(posedge mclk_in);
        instr_valid_in <= s;
        @(negedge mclk_in);
        chk(squash_out, s, "squash");
        chk(skip_out, s, "skip hold");
        @(negedge mclk_in);
        chk(is_bit_test_out, 1'b0, "refused word");
        chk(nop_cycles_out, {1'b0, s && two}, "pending nops");
        if (s && two) begin
            repeat (3) @(negedge mclk_in);
            chk(squash_out, 1'b1, "second squash");
            @(negedge mclk_in);
            chk(nop_cycles_out, 2'h0, "nops done");
        end
        $display("test done word %h skip %0d", w, s);
    endtask
    initial begin
        void'($urandom(24361));
        repeat (3) @(posedge mclk_in);
        rst_in <= 0;
        for (int i = 0; i < 6; i++)
            run_one(cw[i], 8'h55, 1'b1, i[2], 1'b1);
        repeat (150)
            run_one({3'h5, 13'($urandom)}, 8'($urandom), 3'($urandom) != 0, 1'($urandom), 1'($urandom));
        end_of_test;
    end
endmodule
